// *** verilog/wdtu_defs.vh ***
// Contract
// R1 - free-running divider sets timeout flag on interval
// R2 - interrupt only with watchdog and global enable (the irq output ignores the global enable)
// R3 - interrupt and reset paths are independent
// R4 - restart bit restarts count and self-clears
// R5 - select bits pick 2^17/20/23/26 clock timeout
// R6 - timeout sets flag bit 3 regardless of enable
// R7 - reset 512 clocks after timeout when enabled
// R8 - reset lasts two machine cycles, sets cause flag
// R9 - power-on reset disables the watchdog
// R10 - external or watchdog reset restarts count only
// R11 - power-up flag set at power-up, software clears
// R12 - hardware never clears timeout flag
// R13 - cause flag kept unless enabled reset fires; code also clears it on power-on and takes software writes
// R14 - protected bits need AAh then 55h unlock
// R15 - simple timer use: disable both, poll flag
// R16 - interval select resets to zero
// R17 - unlock window closes after few cycles or write
// R18 - restart clears divider and pending countdown
`ifndef WDTU_DEFS_VH
`define WDTU_DEFS_VH
`define WDTU_OFF_CTRL 4'h0
`define WDTU_OFF_CLKCTL 4'h4
`define WDTU_OFF_KEY 4'h8
`define WDTU_OFF_IRQSTAT 4'hC
`define WDTU_OFF_IRQCLR 5'h10
`define WDTU_OFF_IRQEN 5'h14
`define WDTU_OFF_GIE 5'h18
`define WDTU_BIT_RESTART 0
`define WDTU_BIT_RSTEN 1
`define WDTU_BIT_CAUSE 2
`define WDTU_BIT_TOUT 3
`define WDTU_BIT_PWRUP 6
`define WDTU_BIT_SELLO 6
`define WDTU_BIT_SELHI 7
`define WDTU_CTRL_RW_MASK 8'h4E
`define WDTU_KEY_FIRST 8'hAA
`define WDTU_KEY_SECOND 8'h55
`define WDTU_UNLOCK_CYCLES 3'h4
`define WDTU_RESET_DELAY 10'h200
`define WDTU_RESET_LEN 5'h18
`define WDTU_DIV_WIDTH 26
`define WDTU_NUM_IRQ 2
`define WDTU_IRQ_TIMEOUT 0
`define WDTU_IRQ_WDRESET 1
`endif

// *** verilog/wdtu_divider.v ***
`timescale 1ns/1ns
`include "wdtu_defs.vh"
module wdtu_divider #(
    parameter W = `WDTU_DIV_WIDTH
) (
    input wire clk,
    input wire restart,
    input wire [1:0] sel,
    output reg tick_ff
);
    reg [W-1:0] cnt_ff;
    reg [W-1:0] nxt_cnt;
    reg hit;
    always @* begin
        nxt_cnt = cnt_ff + {{(W-1){1'b0}}, 1'b1};
        case (sel)
            2'h0: hit = &cnt_ff[16:0]; // R5
            2'h1: hit = &cnt_ff[19:0];
            2'h2: hit = &cnt_ff[22:0];
            default: hit = &cnt_ff[W-1:0];
        endcase
    end
    always @(posedge clk) begin
        if (restart) begin
            cnt_ff <= {W{1'b0}}; // R18
            tick_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt; // R1
            tick_ff <= hit;
        end
    end
endmodule // wdtu_divider

// *** verilog/wdtu_top.v ***
`timescale 1ns/1ns
`include "wdtu_defs.vh"
module wdtu_top (
    input wire clk,
    input wire reset,
    input wire power_on_reset,
    input wire ext_reset,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output wire wd_irq_req,
    output reg wd_sys_reset_ff,
    output wire irq
);
    // power-on and external reset inputs pass three synchroniser flops and a filter flop
    reg [2:0] por_sync_ff;
    reg [2:0] ext_sync_ff;
    reg por_ff;
    reg ext_ff;
    always @(posedge clk) begin
        if (reset) begin
            por_sync_ff <= 3'h0;
            ext_sync_ff <= 3'h0;
            por_ff <= 1'b0;
            ext_ff <= 1'b0;
        end else begin
            por_sync_ff <= {por_sync_ff[1:0], power_on_reset};
            ext_sync_ff <= {ext_sync_ff[1:0], ext_reset};
            if (por_sync_ff[1] == por_sync_ff[2])
                por_ff <= por_sync_ff[2];
            if (ext_sync_ff[1] == ext_sync_ff[2])
                ext_ff <= ext_sync_ff[2];
        end
    end

    // write channel capture
    reg aw_ff;
    reg w_ff;
    reg [4:0] awaddr_ff;
    reg [31:0] wdata_ff;
    reg wstrb0_ff;
    assign s_axi_awready = ~aw_ff & ~s_axi_bvalid;
    assign s_axi_wready = ~w_ff & ~s_axi_bvalid;
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire have_aw = aw_ff | aw_take;
    wire have_w = w_ff | w_take;
    wire wr_go = have_aw & have_w & ~s_axi_bvalid;
    wire [4:0] wr_addr = aw_take ? s_axi_awaddr[4:0] : awaddr_ff;
    wire [31:0] wr_data = w_take ? s_axi_wdata : wdata_ff;
    wire wr_lane0 = w_take ? s_axi_wstrb[0] : wstrb0_ff;
    wire wr_ok = wr_go & wr_lane0;

    function wr_hit;
        input [4:0] a;
        input [4:0] off;
        begin
            wr_hit = (a[4:2] == off[4:2]);
        end
    endfunction

    wire wr_ctrl = wr_ok & wr_hit(wr_addr, {1'b0, `WDTU_OFF_CTRL});
    wire wr_clk = wr_ok & wr_hit(wr_addr, {1'b0, `WDTU_OFF_CLKCTL});
    wire wr_key = wr_ok & wr_hit(wr_addr, {1'b0, `WDTU_OFF_KEY});
    wire wr_iclr = wr_ok & wr_hit(wr_addr, `WDTU_OFF_IRQCLR);
    wire wr_ien = wr_ok & wr_hit(wr_addr, `WDTU_OFF_IRQEN);
    wire wr_gie = wr_ok & wr_hit(wr_addr, `WDTU_OFF_GIE);
    wire wr_mapped = wr_hit(wr_addr, {1'b0, `WDTU_OFF_CTRL})
        | wr_hit(wr_addr, {1'b0, `WDTU_OFF_CLKCTL}) | wr_hit(wr_addr, {1'b0, `WDTU_OFF_KEY})
        | wr_hit(wr_addr, {1'b0, `WDTU_OFF_IRQSTAT}) | wr_hit(wr_addr, `WDTU_OFF_IRQCLR)
        | wr_hit(wr_addr, `WDTU_OFF_IRQEN) | wr_hit(wr_addr, `WDTU_OFF_GIE);
    wire wr_addr_ok = (s_axi_awaddr[31:5] == 27'h0);
    reg aw_hi_bad_ff;

    always @(posedge clk) begin
        if (reset) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 5'h00;
            wdata_ff <= 32'h00000000;
            wstrb0_ff <= 1'b0;
            aw_hi_bad_ff <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (aw_take) begin
                awaddr_ff <= s_axi_awaddr[4:0];
                aw_hi_bad_ff <= ~wr_addr_ok;
            end
            if (w_take) begin
                wdata_ff <= s_axi_wdata;
                wstrb0_ff <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_mapped & ~(aw_take ? ~wr_addr_ok : aw_hi_bad_ff))
                    ? 2'h0 : 2'h2;
            end else begin
                if (aw_take)
                    aw_ff <= 1'b1;
                if (w_take)
                    w_ff <= 1'b1;
                if (s_axi_bvalid & s_axi_bready)
                    s_axi_bvalid <= 1'b0;
            end
        end
    end

    // timed-access unlock window
    localparam KS_IDLE = 2'h0;
    localparam KS_HALF = 2'h1;
    localparam KS_OPEN = 2'h2;
    reg [1:0] key_state_ff;
    reg [1:0] nxt_key_state;
    reg [2:0] key_cnt_ff;
    wire key_open = (key_state_ff == KS_OPEN);
    wire prot_write = wr_ctrl & key_open; // R14
    always @* begin
        nxt_key_state = key_state_ff;
        case (key_state_ff)
            KS_IDLE: begin
                if (wr_key && wr_data[7:0] == `WDTU_KEY_FIRST)
                    nxt_key_state = KS_HALF;
            end
            KS_HALF: begin
                if (wr_key)
                    nxt_key_state = (wr_data[7:0] == `WDTU_KEY_SECOND) ? KS_OPEN : KS_IDLE; // R17
                else if (key_cnt_ff == `WDTU_UNLOCK_CYCLES)
                    nxt_key_state = KS_IDLE;
            end
            KS_OPEN: begin
                if (prot_write || wr_key || key_cnt_ff == `WDTU_UNLOCK_CYCLES)
                    nxt_key_state = KS_IDLE; // R17
            end
            default: nxt_key_state = KS_IDLE;
        endcase
    end
    always @(posedge clk) begin
        if (reset) begin
            key_state_ff <= KS_IDLE;
            key_cnt_ff <= 3'h0;
        end else begin
            key_state_ff <= nxt_key_state;
            if (nxt_key_state != key_state_ff)
                key_cnt_ff <= 3'h0;
            else if (key_state_ff != KS_IDLE)
                key_cnt_ff <= key_cnt_ff + 3'h1;
        end
    end

    // control bits
    reg pwrup_ff;
    reg tout_ff;
    reg cause_ff;
    reg rsten_ff;
    reg [1:0] sel_ff;
    reg gie_ff;
    reg [`WDTU_NUM_IRQ-1:0] irq_stat_ff;
    reg [`WDTU_NUM_IRQ-1:0] irq_en_ff;
    reg [9:0] rst_cnt_ff;
    reg rst_pend_ff;
    reg [4:0] rst_len_ff;
    reg por_seen_ff;
    wire tick;
    wire restart_wr = prot_write & wr_data[`WDTU_BIT_RESTART]; // R4
    wire por_rise = por_ff & ~por_seen_ff;
    wire wd_reset_fire = rst_pend_ff & (rst_cnt_ff == `WDTU_RESET_DELAY - 10'h1);
    wire ext_restart = ext_ff | wd_sys_reset_ff; // R10
    wire div_restart = restart_wr | ext_restart | reset | por_ff;

    wdtu_divider #(
        .W(`WDTU_DIV_WIDTH)
    ) u_div (
        .clk(clk),
        .restart(div_restart),
        .sel(sel_ff),
        .tick_ff(tick)
    );

    always @(posedge clk) begin
        if (reset) begin
            pwrup_ff <= 1'b0;
            tout_ff <= 1'b0;
            cause_ff <= 1'b0;
            rsten_ff <= 1'b0;
            sel_ff <= 2'h0; // R16
            gie_ff <= 1'b0;
            irq_en_ff <= {`WDTU_NUM_IRQ{1'b0}};
            por_seen_ff <= 1'b0;
        end else begin
            por_seen_ff <= por_ff;
            if (por_ff) begin
                rsten_ff <= 1'b0; // R9
                cause_ff <= 1'b0; // R13
                sel_ff <= 2'h0;
            end else begin
                if (prot_write)
                    rsten_ff <= wr_data[`WDTU_BIT_RSTEN]; // R14
                if (wd_reset_fire & rsten_ff)
                    cause_ff <= 1'b1; // R8
                else if (wr_ctrl)
                    cause_ff <= wr_data[`WDTU_BIT_CAUSE]; // R13
                if (wr_clk)
                    sel_ff <= {wr_data[`WDTU_BIT_SELHI], wr_data[`WDTU_BIT_SELLO]}; // R5
            end
            if (por_rise)
                pwrup_ff <= 1'b1; // R11
            else if (wr_ctrl)
                pwrup_ff <= wr_data[`WDTU_BIT_PWRUP];
            if (tick)
                tout_ff <= 1'b1; // R6 R12
            else if (prot_write)
                tout_ff <= wr_data[`WDTU_BIT_TOUT];
            if (wr_gie)
                gie_ff <= wr_data[0];
            if (wr_ien)
                irq_en_ff <= wr_data[`WDTU_NUM_IRQ-1:0];
        end
    end

    // reset countdown and pulse
    always @(posedge clk) begin
        if (reset || por_ff || restart_wr || ext_ff) begin
            rst_pend_ff <= 1'b0; // R18
            rst_cnt_ff <= 10'h000;
        end else if (tick & rsten_ff & ~rst_pend_ff) begin
            rst_pend_ff <= 1'b1; // R7
            rst_cnt_ff <= 10'h000;
        end else if (rst_pend_ff) begin
            if (wd_reset_fire | ~rsten_ff)
                rst_pend_ff <= 1'b0;
            rst_cnt_ff <= rst_cnt_ff + 10'h001;
        end
    end
    always @(posedge clk) begin
        if (reset || por_ff) begin
            wd_sys_reset_ff <= 1'b0;
            rst_len_ff <= 5'h00;
        end else if (wd_reset_fire & rsten_ff) begin
            wd_sys_reset_ff <= 1'b1; // R7 R3
            rst_len_ff <= `WDTU_RESET_LEN;
        end else if (rst_len_ff != 5'h00) begin
            rst_len_ff <= rst_len_ff - 5'h01; // R8
            if (rst_len_ff == 5'h01)
                wd_sys_reset_ff <= 1'b0;
        end
    end

    assign wd_irq_req = tout_ff & irq_en_ff[`WDTU_IRQ_TIMEOUT] & gie_ff; // R2 R3

    // sticky interrupt status, set wins over clear
    wire [`WDTU_NUM_IRQ-1:0] irq_evt = {wd_reset_fire & rsten_ff, tick};
    wire [`WDTU_NUM_IRQ-1:0] irq_clr = wr_iclr ? wr_data[`WDTU_NUM_IRQ-1:0]
        : {`WDTU_NUM_IRQ{1'b0}};
    genvar gi;
    generate
        for (gi = 0; gi < `WDTU_NUM_IRQ; gi = gi + 1) begin : g_irq
            always @(posedge clk) begin
                if (reset)
                    irq_stat_ff[gi] <= 1'b0;
                else if (irq_evt[gi])
                    irq_stat_ff[gi] <= 1'b1;
                else if (irq_clr[gi])
                    irq_stat_ff[gi] <= 1'b0;
            end
        end
    endgenerate
    assign irq = |(irq_stat_ff & irq_en_ff);

    // read channel
    assign s_axi_arready = ~s_axi_rvalid;
    wire [4:0] ra = s_axi_araddr[4:0];
    reg [31:0] rd_val;
    reg rd_bad;
    always @* begin
        rd_val = 32'h00000000;
        rd_bad = (s_axi_araddr[31:5] != 27'h0);
        case (ra[4:2])
            3'h0: rd_val[7:0] = {1'b0, pwrup_ff, 2'h0, tout_ff, cause_ff, rsten_ff, 1'b0};
            3'h1: rd_val[7:0] = {sel_ff, 6'h00};
            3'h2: rd_val[7:0] = {6'h00, key_state_ff};
            3'h3: rd_val[`WDTU_NUM_IRQ-1:0] = irq_stat_ff;
            3'h4: rd_val = 32'h00000000;
            3'h5: rd_val[`WDTU_NUM_IRQ-1:0] = irq_en_ff;
            3'h6: rd_val[0] = gie_ff;
            default: rd_bad = 1'b1;
        endcase
    end
    always @(posedge clk) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_bad ? 32'h00000000 : rd_val;
            s_axi_rresp <= rd_bad ? 2'h2 : 2'h0;
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // wdtu_top

// *** dv/wdtu_checker.sv ***
`timescale 1ns/1ns
module wdtu_checker (
    input wire clk,
    input wire reset,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire wd_sys_reset_ff,
    input wire irq
);
    reg [4:0] len_ff;
    wire [4:0] nxt_len = wd_sys_reset_ff ? len_ff + 5'h01 : 5'h00;
    always @(posedge clk) begin
        len_ff <= nxt_len;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_pulse_len: assert property ($fell(wd_sys_reset_ff) |-> len_ff == 5'h18)
        else $error("watchdog reset pulse length wrong");
    a_pulse_gap: assert property ($fell(wd_sys_reset_ff) |=> !wd_sys_reset_ff [*8])
        else $error("watchdog reset repeated at once");
    a_reset_clears: assert property (disable iff (1'b0)
        reset |=> !wd_sys_reset_ff && !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not cleared by reset");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read response dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
endmodule // wdtu_checker
bind wdtu_top wdtu_checker chk_u (.clk(clk), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .wd_sys_reset_ff(wd_sys_reset_ff), .irq(irq));

// *** dv/wdtu_core_model.sv ***
`timescale 1ns/1ns
module wdtu_core_model (
    input wire clk,
    input wire por_cmd,
    input wire ext_cmd,
    input wire wd_sys_reset_ff,
    output wire power_on_reset,
    output wire ext_reset,
    output reg [7:0] wd_reset_count
);
    reg [2:0] por_ff = 3'h0;
    reg [2:0] ext_ff = 3'h0;
    reg last_ff = 1'b0;
    // reset requests stretched to four clocks for the synchronisers
    assign power_on_reset = por_ff != 3'h0;
    assign ext_reset = ext_ff != 3'h0;
    initial wd_reset_count = 8'h00;
    always @(posedge clk) begin
        por_ff <= por_cmd ? 3'h4 : por_ff - {2'h0, power_on_reset};
        ext_ff <= ext_cmd ? 3'h4 : ext_ff - {2'h0, ext_reset};
        last_ff <= wd_sys_reset_ff;
        if (wd_sys_reset_ff && !last_ff) begin
            wd_reset_count <= wd_reset_count + 8'h01;
        end
    end
endmodule // wdtu_core_model

// *** dv/wdtu_top_test.sv ***
`timescale 1ns/1ns
module wdtu_top_test;
    typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} wdtu_note_t;
    wdtu_note_t notes[$];
    wdtu_note_t n;
    reg clk = 1'b0;
    reg reset = 1'b1;
    reg por_cmd = 1'b0;
    reg ext_cmd = 1'b0;
    reg [31:0] aw_addr = 32'h0;
    reg [31:0] w_data = 32'h0;
    reg [31:0] ar_addr = 32'h0;
    reg aw_vld = 1'b0;
    reg w_vld = 1'b0;
    reg b_rdy = 1'b0;
    reg ar_vld = 1'b0;
    reg r_rdy = 1'b0;
    wire aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, wd_req, wd_rst, irq, por, ext;
    wire [1:0] b_resp;
    wire [1:0] r_resp;
    wire [31:0] r_data;
    wire [7:0] wd_resets;
    int num_errors = 0;
    int checks = 0;
    int cyc = 0;
    int t0 = 0;
    reg [31:0] lfsr = 32'hCF38;
    always #20 clk = ~clk;
    wdtu_top dut_u (.clk(clk), .reset(reset), .power_on_reset(por), .ext_reset(ext),
        .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_vld), .s_axi_awready(aw_rdy),
        .s_axi_wdata(w_data), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_vld), .s_axi_wready(w_rdy),
        .s_axi_bresp(b_resp), .s_axi_bvalid(b_vld), .s_axi_bready(b_rdy),
        .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_vld), .s_axi_arready(ar_rdy),
        .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_vld), .s_axi_rready(r_rdy),
        .wd_irq_req(wd_req), .wd_sys_reset_ff(wd_rst), .irq(irq));
    wdtu_core_model core_u (.clk(clk), .por_cmd(por_cmd), .ext_cmd(ext_cmd),
        .wd_sys_reset_ff(wd_rst), .power_on_reset(por), .ext_reset(ext),
        .wd_reset_count(wd_resets));
    function automatic [31:0] next_rand(input [31:0] s);
        next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_span(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("wrong value at %0t: delay %0d", $time, got);
        end
    endtask
    task automatic wr(input [7:0] a, input [31:0] d, input [1:0] r, input bit slow);
        notes.push_back(wdtu_note_t'{32'h0, 32'h0, r});
        aw_addr <= {24'h0, a};
        w_data <= d;
        aw_vld <= 1'b1;
        w_vld <= 1'b1;
        b_rdy <= !slow;
        do begin
            @(posedge clk);
            if (aw_rdy) aw_vld <= 1'b0;
            if (w_rdy) w_vld <= 1'b0;
        end while ((aw_vld && !aw_rdy) || (w_vld && !w_rdy));
        while (!b_vld) @(posedge clk);
        if (slow) begin
            b_rdy <= 1'b1;
            @(posedge clk);
        end
    endtask
    task automatic rd(input [7:0] a, input [31:0] d, input [1:0] r);
        notes.push_back(wdtu_note_t'{d, (a == 8'h00) ? 32'h4F : (a == 8'h04) ? 32'hC0 :
            (a == 8'h0C) ? 32'h3 : 32'hFFFFFFFF, r});
        ar_addr <= {24'h0, a};
        ar_vld <= 1'b1;
        do @(posedge clk); while (!ar_rdy);
        ar_vld <= 1'b0;
        while (!r_vld) @(posedge clk);
        r_rdy <= 1'b1;
        @(posedge clk);
        r_rdy <= 1'b0;
    endtask
    task automatic unlock;
        wr(8'h08, 32'hAA, 2'b00, 0);
        wr(8'h08, 32'h55, 2'b00, 0);
    endtask
    task automatic pulse(input bit p);
        if (p) por_cmd <= 1'b1;
        else ext_cmd <= 1'b1;
        @(posedge clk);
        por_cmd <= 1'b0;
        ext_cmd <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
    task automatic end_sim;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // results leave in request order, one bus transfer at a time
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (b_vld && b_rdy) begin
            n = notes.pop_front();
            cmp_word({30'h0, b_resp}, {30'h0, n.r});
        end
        if (r_vld && r_rdy) begin
            n = notes.pop_front();
            cmp_word(r_data & n.m, n.d & n.m);
            cmp_word({30'h0, r_resp}, {30'h0, n.r});
        end
        if (cyc == 140000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        pulse(1);
        rd(8'h00, 32'h40, 2'b00);
        rd(8'h04, 32'h00, 2'b00);
        for (int i = 1; i < 5; i++) begin
            wr(8'h04, {24'h0, i[1:0], 6'h0}, 2'b00, 1);
            rd(8'h04, {24'h0, i[1:0], 6'h0}, 2'b00);
        end
        lfsr = next_rand(lfsr);
        wr(8'h1C, lfsr, 2'b10, 1);
        rd(8'h1C, 32'h0, 2'b10);
        wr(8'h0C, lfsr, 2'b00, 0);
        rd(8'h0C, 32'h0, 2'b00);
        wr(8'h00, 32'h2, 2'b00, 0);
        wr(8'h08, 32'h55, 2'b00, 0);
        wr(8'h08, 32'hAA, 2'b00, 0);
        wr(8'h00, 32'h2, 2'b00, 0);
        unlock();
        repeat (10) @(posedge clk);
        wr(8'h00, 32'h2, 2'b00, 0);
        rd(8'h00, 32'h00, 2'b00);
        unlock();
        wr(8'h00, 32'h3, 2'b00, 0);
        wr(8'h00, 32'h0, 2'b00, 0);
        rd(8'h00, 32'h02, 2'b00);
        wr(8'h14, 32'h3, 2'b00, 0);
        wr(8'h18, 32'h1, 2'b00, 0);
        pulse(0);
        rd(8'h00, 32'h02, 2'b00);
        unlock();
        wr(8'h00, 32'h3, 2'b00, 0);
        t0 = cyc;
        while (!wd_req) @(posedge clk);
        cmp_span(cyc - t0, 131060, 131080);
        t0 = cyc;
        while (!wd_rst) @(posedge clk);
        cmp_span(cyc - t0, 510, 514);
        while (wd_rst) @(posedge clk);
        cmp_word({24'h0, wd_resets}, 32'h1);
        cmp_word({31'h0, irq}, 32'h1);
        rd(8'h00, 32'h0E, 2'b00);
        rd(8'h0C, 32'h3, 2'b00);
        wr(8'h10, 32'h3, 2'b00, 0);
        cmp_word({30'h0, irq, wd_req}, 32'h1);
        wr(8'h18, 32'h0, 2'b00, 0);
        cmp_word({31'h0, wd_req}, 32'h0);
        wr(8'h00, 32'h0A, 2'b00, 0);
        rd(8'h00, 32'h0A, 2'b00);
        unlock();
        wr(8'h00, 32'h0, 2'b00, 0);
        rd(8'h00, 32'h00, 2'b00);
        unlock();
        wr(8'h00, 32'h2, 2'b00, 0);
        pulse(1);
        rd(8'h00, 32'h40, 2'b00);
        end_sim();
    end
endmodule // wdtu_top_test
